/* hw/mas_defines.svh */
// offsets, field positions, reset values and sizes for the address sequencer
`ifndef MAS_DEFINES_SVH
`define MAS_DEFINES_SVH

`define MAS_AW              12
`define MAS_STACK_WORDS     9
`define MAS_STACK_FULL      4'h9
`define MAS_STACK_TOP_IDX   4'h8

`define MAS_OFS_CTRL        4'h0
`define MAS_OFS_STATUS      4'h4
`define MAS_OFS_LOOP        4'h8

`define MAS_CTRL_HIZ_BIT    0
`define MAS_STATUS_SP_LSB   0
`define MAS_STATUS_FULL_BIT 4
`define MAS_STATUS_Y_LSB    16
`define MAS_LOOP_CNT_LSB    0
`define MAS_LOOP_PC_LSB     16

`define MAS_CTRL_HIZ_RST    1'h0
`define MAS_WAIT_RST        1'h1

`endif

/* hw/mas_pkg.sv */
// types shared by the address sequencer
package mas_pkg;

    typedef enum logic [2:0] {
        SRC_CNT,
        SRC_D,
        SRC_PC,
        SRC_TOS,
        SRC_ZERO
    } mas_src_t;

    typedef enum logic [1:0] {
        STK_HOLD,
        STK_PUSH,
        STK_POP,
        STK_CLEAR
    } mas_stk_t;

    typedef enum logic [1:0] {
        CNT_HOLD,
        CNT_DEC,
        CNT_LOAD
    } mas_cnt_t;

    typedef enum logic [1:0] {
        EN_PIPE,
        EN_MAP,
        EN_THIRD
    } mas_en_t;

    typedef struct packed {
        logic [11:0]       pc;
        logic [11:0]       cnt;
        logic [3:0]        sp;
        logic [8:0][11:0]  stk;
        logic [11:0]       y;
        logic              y_oe;
        logic              pipe_n;
        logic              map_n;
        logic              third_n;
        logic              full_n;
        logic              force_hiz;
        logic              wait_r;
        logic [31:0]       rdata;
    } mas_state_t;

endpackage

/* hw/mas_sequencer.sv */
// microprogram address sequencer with avalon status and control slave
//
// Implementation choices: the address map and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`include "mas_defines.svh"

module mas_sequencer
    import mas_pkg::*;
(
    input  wire logic        clk_in,
    input  wire logic        rst_n_in,
    input  wire logic [3:0]  instr_in,
    input  wire logic        cond_test_n_in,
    input  wire logic        cond_gate_n_in,
    input  wire logic        incr_carry_in,
    input  wire logic        count_load_n_in,
    input  wire logic        addr_en_n_in,
    input  wire logic [11:0] branch_in,
    output logic [11:0]      next_addr_out,
    output logic             next_addr_oe_out,
    output logic             pipe_src_oe_n_out,
    output logic             map_src_oe_n_out,
    output logic             third_src_oe_n_out,
    output logic             stack_full_n_out,
    input  wire logic [3:0]  avs_address_in,
    input  wire logic        avs_read_in,
    input  wire logic        avs_write_in,
    input  wire logic [31:0] avs_writedata_in,
    input  wire logic [3:0]  avs_byteenable_in,
    output logic [31:0]      avs_readdata_out,
    output logic             avs_waitrequest_out
);

    // top of stack; an empty stack reads as zero rather than stale data
    function automatic logic [11:0] mas_tos(input logic [8:0][11:0] s, input logic [3:0] p);
        logic [3:0] i;
        i = p - 4'h1;
        if (p == 4'h0) begin
            return 12'h000;
        end
        return s[i];
    endfunction

    mas_state_t st_q;
    mas_state_t st_d;
    mas_src_t   src;
    mas_stk_t   sop;
    mas_cnt_t   cop;
    mas_en_t    en;
    logic       fail;
    logic       cz;
    logic [11:0] y;
    logic [3:0]  wr_idx;
    logic        req;

    assign fail = !cond_gate_n_in && cond_test_n_in;
    assign cz   = (st_q.cnt == 12'h000);
    assign req  = avs_read_in || avs_write_in;

    always_comb begin
        st_d   = st_q;
        src    = SRC_PC;
        sop    = STK_HOLD;
        cop    = CNT_HOLD;
        en     = EN_PIPE;
        wr_idx = 4'h0;
        // instruction decode
        case (instr_in)
            4'h0: begin
                src = SRC_ZERO;
                sop = STK_CLEAR;
            end
            4'h1: begin
                src = fail ? SRC_PC : SRC_D;
                sop = fail ? STK_HOLD : STK_PUSH;
            end
            4'h2: begin
                src = SRC_D;
                en  = EN_MAP;
            end
            4'h3: begin
                src = fail ? SRC_PC : SRC_D;
            end
            4'h4: begin
                src = SRC_PC;
                sop = STK_PUSH;
                cop = fail ? CNT_HOLD : CNT_LOAD;
            end
            4'h5: begin
                src = fail ? SRC_CNT : SRC_D;
                sop = STK_PUSH;
            end
            4'h6: begin
                src = fail ? SRC_PC : SRC_D;
                en  = EN_THIRD;
            end
            4'h7: begin
                src = fail ? SRC_CNT : SRC_D;
            end
            4'h8: begin
                src = cz ? SRC_PC : SRC_TOS;
                sop = cz ? STK_POP : STK_HOLD;
                cop = cz ? CNT_HOLD : CNT_DEC;
            end
            4'h9: begin
                src = cz ? SRC_PC : SRC_D;
                cop = cz ? CNT_HOLD : CNT_DEC;
            end
            4'hA: begin
                src = fail ? SRC_PC : SRC_TOS;
                sop = fail ? STK_HOLD : STK_POP;
            end
            4'hB: begin
                src = fail ? SRC_PC : SRC_D;
                sop = fail ? STK_HOLD : STK_POP;
            end
            4'hC: begin
                cop = CNT_LOAD;
            end
            4'hD: begin
                src = fail ? SRC_TOS : SRC_PC;
                sop = fail ? STK_HOLD : STK_POP;
            end
            4'hE: begin
                src = SRC_PC;
            end
            default: begin
                // three-way branch on counter and condition
                if (!cz) begin
                    src = fail ? SRC_TOS : SRC_PC;
                    sop = fail ? STK_HOLD : STK_POP;
                    cop = CNT_DEC;
                end else begin
                    src = fail ? SRC_D : SRC_PC;
                    sop = STK_POP;
                end
            end
        endcase

        // five-way address selector: counter, branch input, top of stack, zero, or sequence counter
        case (src)
            SRC_CNT:  y = st_q.cnt;
            SRC_D:    y = branch_in;
            SRC_TOS:  y = mas_tos(st_q.stk, st_q.sp);
            SRC_ZERO: y = 12'h000;
            default:  y = st_q.pc;
        endcase

        st_d.pc = y + {11'h000, incr_carry_in};

        // count load wins over the instruction's own action
        if (!count_load_n_in) begin
            st_d.cnt = branch_in;
        end else begin
            case (cop)
                CNT_DEC:  st_d.cnt = st_q.cnt - 12'h001;
                CNT_LOAD: st_d.cnt = branch_in;
                default:  st_d.cnt = st_q.cnt;
            endcase
        end

        // return linkage is always the sequence counter
        case (sop)
            STK_PUSH: begin
                if (st_q.sp == `MAS_STACK_FULL) begin
                    wr_idx = `MAS_STACK_TOP_IDX;
                end else begin
                    wr_idx  = st_q.sp;
                    st_d.sp = st_q.sp + 4'h1;
                end
                st_d.stk[wr_idx] = st_q.pc;
            end
            STK_POP: begin
                if (st_q.sp != 4'h0) begin
                    st_d.sp = st_q.sp - 4'h1;
                end // empty stays at zero
            end
            STK_CLEAR: st_d.sp = 4'h0;
            default: st_d.sp = st_q.sp;
        endcase

        // outputs are registered, so they show the previous decode
        st_d.full_n = (st_d.sp != `MAS_STACK_FULL);
        st_d.y      = y;
        st_d.y_oe   = !(addr_en_n_in || st_q.force_hiz);
        st_d.pipe_n  = (en != EN_PIPE);
        st_d.map_n   = (en != EN_MAP);
        st_d.third_n = (en != EN_THIRD);

        // bus slave: one wait cycle, then a single answer cycle
        st_d.wait_r = `MAS_WAIT_RST;
        if (req && st_q.wait_r) begin
            st_d.wait_r = 1'b0;
            case (avs_address_in)
                `MAS_OFS_CTRL: begin
                    st_d.rdata = 32'h0000_0000;
                    st_d.rdata[`MAS_CTRL_HIZ_BIT] = st_q.force_hiz;
                end
                `MAS_OFS_STATUS: begin
                    st_d.rdata = 32'h0000_0000;
                    st_d.rdata[`MAS_STATUS_SP_LSB +: 4]  = st_q.sp;
                    st_d.rdata[`MAS_STATUS_FULL_BIT]     = !st_q.full_n;
                    st_d.rdata[`MAS_STATUS_Y_LSB +: 12]  = st_q.y;
                end
                `MAS_OFS_LOOP: begin
                    st_d.rdata = 32'h0000_0000;
                    st_d.rdata[`MAS_LOOP_CNT_LSB +: 12] = st_q.cnt;
                    st_d.rdata[`MAS_LOOP_PC_LSB +: 12]  = st_q.pc;
                end
                default: st_d.rdata = 32'h0000_0000;
            endcase
        end
        // a write lands at the edge where waitrequest is seen low
        if (avs_write_in && !st_q.wait_r && avs_address_in == `MAS_OFS_CTRL && avs_byteenable_in[0]) begin
            st_d.force_hiz = avs_writedata_in[`MAS_CTRL_HIZ_BIT];
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            st_q           <= '0;
            st_q.full_n    <= 1'b1;
            st_q.map_n     <= 1'b1;
            st_q.third_n   <= 1'b1;
            st_q.force_hiz <= `MAS_CTRL_HIZ_RST;
            st_q.wait_r    <= `MAS_WAIT_RST;
        end else begin
            st_q <= st_d;
        end
    end

    assign next_addr_out       = st_q.y;
    assign next_addr_oe_out    = st_q.y_oe;
    assign pipe_src_oe_n_out   = st_q.pipe_n;
    assign map_src_oe_n_out    = st_q.map_n;
    assign third_src_oe_n_out  = st_q.third_n;
    assign stack_full_n_out    = st_q.full_n;
    assign avs_readdata_out    = st_q.rdata;
    assign avs_waitrequest_out = st_q.wait_r;

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);

    cond_fail_a: assert property (
        $past(instr_in == 4'h3 && !cond_gate_n_in && cond_test_n_in && count_load_n_in)
        |-> next_addr_out == $past(st_q.pc))
        else $error("failed condition did not continue");

    gate_pass_a: assert property (
        $past(instr_in == 4'h3 && cond_gate_n_in) |-> next_addr_out == $past(branch_in))
        else $error("gated condition did not branch");

    full_flag_a: assert property (
        stack_full_n_out == (st_q.sp != `MAS_STACK_FULL))
        else $error("full flag disagrees with depth");

    hiz_ctl_a: assert property (
        $past(addr_en_n_in) |-> !next_addr_oe_out)
        else $error("address driven while disabled");

    cnt_load_a: assert property (
        $past(!count_load_n_in) |-> st_q.cnt == $past(branch_in))
        else $error("count load ignored");

    seq_inc_a: assert property (
        $past(rst_n_in) |-> st_q.pc == next_addr_out + {11'h000, $past(incr_carry_in)})
        else $error("sequence counter wrong");

    // checked one cycle on only: a following push or clear may legally move the top
    push_ptr_a: assert property (
        $past(instr_in == 4'h4 && st_q.sp < `MAS_STACK_FULL)
        |-> st_q.sp == $past(st_q.sp) + 4'h1 && mas_tos(st_q.stk, st_q.sp) == $past(st_q.pc))
        else $error("push did not raise pointer");

    // flag must show in the very cycle after the ninth push, not later
    full_rise_a: assert property (
        $past(st_q.sp == 4'h8 && sop == STK_PUSH) |-> !stack_full_n_out)
        else $error("full flag late after ninth push");

    pop_dec_a: assert property (
        $past(sop == STK_POP && st_q.sp != 4'h0) |-> st_q.sp == $past(st_q.sp) - 4'h1)
        else $error("pop did not lower pointer");

    full_push_a: assert property (
        $past(instr_in == 4'h4 && st_q.sp == `MAS_STACK_FULL)
        |-> st_q.sp == `MAS_STACK_FULL && st_q.stk[8] == $past(st_q.pc))
        else $error("push on full stack misbehaved");

    empty_pop_a: assert property (
        $past(instr_in == 4'hA && st_q.sp == 4'h0) |-> st_q.sp == 4'h0)
        else $error("pop on empty stack moved pointer");

    clear_stack_a: assert property (
        $past(instr_in == 4'h0) |-> st_q.sp == 4'h0 && next_addr_out == 12'h000)
        else $error("jump zero did not clear");

    onehot_en_a: assert property (
        $onehot({!pipe_src_oe_n_out, !map_src_oe_n_out, !third_src_oe_n_out}))
        else $error("source enables not one-hot");

    down_count_a: assert property (
        $past(instr_in == 4'h9 && st_q.cnt != 12'h000 && count_load_n_in)
        |-> st_q.cnt == $past(st_q.cnt) - 12'h001)
        else $error("counter did not decrement");

    twb_exit_a: assert property (
        $past(instr_in == 4'hF && st_q.cnt == 12'h000 && fail)
        |-> next_addr_out == $past(branch_in))
        else $error("three-way branch exit wrong");

    full_seen_c: cover property (!stack_full_n_out);
    twb_loop_c: cover property (instr_in == 4'hF && !cz && fail);
    third_sel_c: cover property (!third_src_oe_n_out);
    twb_exit_c: cover property (instr_in == 4'hF && cz && fail);
    empty_pop_c: cover property (instr_in == 4'hB && !fail && st_q.sp == 4'h0);

endmodule

/* verification/mas_src_model.sv */
// branch sources facing the sequencer, each gated by its own enable
`timescale 1ns/1ps
module mas_src_model (
    input  wire logic        pipe_src_oe_n_in,
    input  wire logic        map_src_oe_n_in,
    input  wire logic        third_src_oe_n_in,
    input  wire logic [11:0] pipe_val_in,
    input  wire logic [11:0] map_val_in,
    input  wire logic [11:0] third_val_in,
    output logic      [11:0] branch_out
);
    // no single source enabled: lines float, show a pattern none holds
    always_comb begin
        case ({pipe_src_oe_n_in, map_src_oe_n_in, third_src_oe_n_in})
            3'h3:    branch_out = pipe_val_in;
            3'h5:    branch_out = map_val_in;
            3'h6:    branch_out = third_val_in;
            default: branch_out = ~(pipe_val_in ^ map_val_in ^ third_val_in);
        endcase
    end
endmodule

/* verification/mas_sequencer_tb.sv */
// self-checking bench for the address sequencer
`timescale 1ns/1ps
module mas_sequencer_tb;
    localparam int LOOP_N = 3;
    logic        clk_in = 1'b0, rst_n_in = 1'b0, cond_test_n_in = 1'b0, cond_gate_n_in = 1'b1;
    logic        incr_carry_in = 1'b1, count_load_n_in = 1'b1, addr_en_n_in = 1'b0;
    logic        avs_read_in = 1'b0, avs_write_in = 1'b0;
    logic [3:0]  instr_in = 4'hE, avs_address_in = 4'h0;
    logic [31:0] avs_writedata_in = 32'h0, avs_readdata_out, rd, r;
    logic [11:0] pipe_val = 12'h000, map_val = 12'h000, third_val = 12'h000;
    logic [11:0] branch_in, next_addr_out, m_pc, m_cnt, m_y, y, d, tos;
    logic [11:0] m_stk [9];
    logic        next_addr_oe_out, pipe_src_oe_n_out, map_src_oe_n_out, third_src_oe_n_out;
    logic        stack_full_n_out, avs_waitrequest_out, m_oe, fl, z, dir;
    logic        m_hiz = 1'b0, quiet = 1'b1, pushed = 1'b0;
    logic [3:0]  m_sp;
    logic [2:0]  m_en;
    logic [4:0]  ent;
    logic [4:0]  dir_q [$];
    int          sa, ca, failures = 0, tests_run = 0, cycles = 0, seed = 72323;
    wire logic [2:0] en_seen = {pipe_src_oe_n_out, map_src_oe_n_out, third_src_oe_n_out};

    always #5 clk_in = ~clk_in;

    mas_src_model SRC (.pipe_src_oe_n_in(pipe_src_oe_n_out), .map_src_oe_n_in(map_src_oe_n_out),
        .third_src_oe_n_in(third_src_oe_n_out), .pipe_val_in(pipe_val), .map_val_in(map_val),
        .third_val_in(third_val), .branch_out(branch_in));

    mas_sequencer DUT (.clk_in(clk_in), .rst_n_in(rst_n_in), .instr_in(instr_in),
        .cond_test_n_in(cond_test_n_in), .cond_gate_n_in(cond_gate_n_in), .incr_carry_in(incr_carry_in),
        .count_load_n_in(count_load_n_in), .addr_en_n_in(addr_en_n_in), .branch_in(branch_in),
        .next_addr_out(next_addr_out), .next_addr_oe_out(next_addr_oe_out),
        .pipe_src_oe_n_out(pipe_src_oe_n_out), .map_src_oe_n_out(map_src_oe_n_out),
        .third_src_oe_n_out(third_src_oe_n_out), .stack_full_n_out(stack_full_n_out),
        .avs_address_in(avs_address_in), .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
        .avs_writedata_in(avs_writedata_in), .avs_byteenable_in(4'hF), .avs_readdata_out(avs_readdata_out),
        .avs_waitrequest_out(avs_waitrequest_out));

    task automatic compare(input string name, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic test_done();
        $display("comparisons %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // reference model: one instruction per edge, state read before update
    task automatic step();
        fl = !cond_gate_n_in && cond_test_n_in;
        d = (m_en == 3'h5) ? map_val : (m_en == 3'h6) ? third_val : pipe_val;
        tos = (m_sp == 4'h0) ? 12'h000 : m_stk[m_sp - 4'h1];
        z = (m_cnt == 12'h000);
        y = m_pc;
        sa = 0;
        ca = 0;
        m_en = 3'h3;
        case (instr_in)
            4'h0: begin y = 12'h000; sa = 3; end
            4'h1: begin y = fl ? m_pc : d; sa = fl ? 0 : 1; end
            4'h2: begin y = d; m_en = 3'h5; end
            4'h3: y = fl ? m_pc : d;
            4'h4: begin sa = 1; ca = fl ? 0 : 2; end
            4'h5: begin y = fl ? m_cnt : d; sa = 1; end
            4'h6: begin y = fl ? m_pc : d; m_en = 3'h6; end
            4'h7: y = fl ? m_cnt : d;
            4'h8: begin y = z ? m_pc : tos; sa = z ? 2 : 0; ca = z ? 0 : 1; end
            4'h9: begin y = z ? m_pc : d; ca = z ? 0 : 1; end
            4'hA: begin y = fl ? m_pc : tos; sa = fl ? 0 : 2; end
            4'hB: begin y = fl ? m_pc : d; sa = fl ? 0 : 2; end
            4'hC: ca = 2;
            4'hD: begin y = fl ? tos : m_pc; sa = fl ? 0 : 2; end
            4'hF: begin y = z ? (fl ? d : m_pc) : (fl ? tos : m_pc); sa = (z || !fl) ? 2 : 0; ca = z ? 0 : 1; end
            default: ;
        endcase
        if (!count_load_n_in || ca == 2) m_cnt = d;
        else if (ca == 1) m_cnt = m_cnt - 12'h001;
        if (sa == 1 && m_sp == 4'h9) m_stk[8] = m_pc;
        else if (sa == 1) begin
            m_stk[m_sp] = m_pc;
            m_sp++;
        end else if (sa == 2 && m_sp != 4'h0) m_sp--;
        else if (sa == 3) m_sp = 4'h0;
        m_pc = y + {11'h000, incr_carry_in};
        m_y = y;
        m_oe = !(addr_en_n_in || m_hiz);
    endtask

    // directed entries first, then a frozen loop, otherwise random
    task automatic drive();
        r = $random(seed);
        dir = dir_q.size() != 0;
        if (dir) ent = dir_q.pop_front();
        else if (quiet) ent = 5'h0E;
        else ent = {r[2:0] == 3'h0, r[7:4]};
        if (pushed && ent[3:0] inside {4'h8, 4'hA, 4'hB, 4'hD, 4'hF}) ent[3:0] = 4'hE;
        pushed = ent[3:0] inside {4'h1, 4'h4, 4'h5};
        instr_in <= ent[3:0];
        count_load_n_in <= !ent[4];
        pipe_val <= (dir && ent[4]) ? 12'(LOOP_N) : r[19:8];
        map_val <= r[31:20];
        third_val <= r[27:16];
        cond_test_n_in <= r[8];
        // directed three-way branches keep a random condition so the fail exit is reached
        cond_gate_n_in <= (dir ? ent[3:0] != 4'hF : quiet) || r[9];
        incr_carry_in <= !quiet && r[12:10] != 3'h0;
        addr_en_n_in <= !dir && !quiet && r[15:13] == 3'h0;
    endtask

    always @(posedge clk_in) begin
        cycles++;
        if (!rst_n_in) begin
            m_pc = 12'h000;
            m_cnt = 12'h000;
            m_y = 12'h000;
            m_sp = 4'h0;
            m_en = 3'h3;
            m_oe = 1'b0;
        end else begin
            if (m_oe) compare("address", {20'h0, m_y}, {20'h0, next_addr_out});
            compare("addr_oe", {31'h0, m_oe}, {31'h0, next_addr_oe_out});
            compare("enables", {29'h0, m_en}, {29'h0, en_seen});
            compare("full_n", {31'h0, m_sp != 4'h9}, {31'h0, stack_full_n_out});
            step();
        end
        drive();
        if (cycles == 20000) begin
            failures++;
            test_done();
        end
    end

    task automatic bus_rd(input logic [3:0] a, output logic [31:0] v);
        @(posedge clk_in);
        avs_address_in <= a;
        avs_read_in <= 1'b1;
        do @(posedge clk_in); while (avs_waitrequest_out !== 1'b0);
        v = avs_readdata_out;
        avs_read_in <= 1'b0;
    endtask

    task automatic bus_wr(input logic [3:0] a, input logic [31:0] v);
        @(posedge clk_in);
        avs_address_in <= a;
        avs_writedata_in <= v;
        avs_write_in <= 1'b1;
        do @(posedge clk_in); while (avs_waitrequest_out !== 1'b0);
        avs_write_in <= 1'b0;
    endtask

    task automatic run(input logic [4:0] e, input int n);
        @(negedge clk_in);
        repeat (n) dir_q.push_back(e);
        while (dir_q.size() != 0) @(posedge clk_in);
        repeat (3) @(posedge clk_in);
    endtask

    task automatic random_phase(input int n);
        @(negedge clk_in);
        quiet = 1'b0;
        repeat (n) @(posedge clk_in);
        @(negedge clk_in);
        quiet = 1'b1;
        repeat (3) @(posedge clk_in);
        bus_rd(4'h4, rd);
        compare("status", {4'h0, m_y, 11'h000, m_sp == 4'h9, m_sp}, rd);
        bus_rd(4'h8, rd);
        compare("loop", {4'h0, m_pc, 4'h0, m_cnt}, rd);
    endtask

    initial begin
        repeat (20) @(posedge clk_in);
        rst_n_in <= 1'b1;
        random_phase(3000);
        bus_wr(4'hC, 32'hFFFFFFFF);
        bus_rd(4'hC, rd);
        compare("unmapped", 32'h0, rd);
        bus_wr(4'h0, 32'h1);
        m_hiz <= 1'b1;
        bus_rd(4'h0, rd);
        compare("ctrl", 32'h1, rd);
        bus_wr(4'h0, 32'h0);
        m_hiz <= 1'b0;
        run(5'h00, 1);
        run(5'h04, 10);
        bus_rd(4'h4, rd);
        compare("depth full", 32'h19, rd & 32'h1F);
        run(5'h0A, 10);
        bus_rd(4'h4, rd);
        compare("depth empty", 32'h0, rd & 32'h1F);
        run(5'h1E, 1);
        run(5'h09, LOOP_N + 1);
        bus_rd(4'h8, rd);
        compare("loop end", 32'h0, rd & 32'hFFF);
        run(5'h0F, 16);
        random_phase(2000);
        test_done();
    end
endmodule
